// File: core/cswt_pkg.sv
package cswt_pkg;

  localparam int CLK_NS = 40;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam int INT_LOW_US = 100;
  localparam int INT_LOW_CYC = INT_LOW_US * 1000 / CLK_NS;

  localparam logic [7:0] ADDR_TMR1 = 8'h00;
  localparam logic [7:0] ADDR_TMR2 = 8'h01;
  localparam logic [7:0] ADDR_HS_CFG = 8'h02;
  localparam logic [7:0] ADDR_WK_CFG = 8'h03;
  localparam logic [7:0] ADDR_WAKE_STATUS_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_WK_LVL = 8'h05;
  localparam logic [7:0] ADDR_FAULT = 8'h06;

  localparam int TMR_ON_LSB = 0;
  localparam int TMR_PER_LSB = 4;
  localparam int HS_SEL_W = 2;
  localparam int WK_EN_LSB = 0;
  localparam int WK_CS_LSB = 3;
  localparam int WK_CW_LSB = 6;
  localparam int STAT_WK_LSB = 0;
  localparam int STAT_CW_LSB = 4;
  localparam int FLT_CMD_BIT = 0;
  localparam int FLT_HSDIS_LSB = 1;

  localparam logic [7:0] TMR_RST = 8'h00;
  localparam logic [7:0] HS_CFG_RST = 8'h00;
  localparam logic [7:0] WK_CFG_RST = 8'h00;

  localparam logic [2:0] ON_OFF = 3'h0;
  localparam logic [2:0] ON_OFF_LOW = 3'h6;
  localparam logic [2:0] ON_OFF_HIGH = 3'h7;

  localparam logic [1:0] HS_OFF = 2'h0;
  localparam logic [1:0] HS_T1 = 2'h1;
  localparam logic [1:0] HS_T2 = 2'h2;
  localparam logic [1:0] HS_SYNC = 2'h3;

  localparam int ON_US [8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
  localparam int PER_MS [8] = '{10, 20, 50, 100, 200, 500, 1000, 2000};

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } cswt_mode_t;

  function automatic logic cswt_on_valid(input logic [2:0] c);
    return (c != ON_OFF) && (c != ON_OFF_LOW) && (c != ON_OFF_HIGH);
  endfunction

  function automatic logic [14:0] cswt_on_ticks(input logic [2:0] c);
    return 15'(ON_US[c] / TICK_US);
  endfunction

  function automatic logic [14:0] cswt_per_ticks(input logic [2:0] c);
    return 15'(PER_MS[c] * 1000 / TICK_US);
  endfunction

endpackage

// File: core/cswt_tmr_if.sv
interface cswt_tmr_if;
  logic tick;
  logic [2:0] period_code;
  logic [2:0] ontime_code;
  logic running;
  logic on_phase;
  logic cycle_start;

  modport core (
    input tick,
    input period_code,
    input ontime_code,
    output running,
    output on_phase,
    output cycle_start
  );

  modport ctl (
    output tick,
    output period_code,
    output ontime_code,
    input running,
    input on_phase,
    input cycle_start
  );
endinterface

// File: core/cswt_timer.sv
module cswt_timer
  import cswt_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  cswt_tmr_if.core t
);

  logic [14:0] cnt_reg;
  logic [14:0] cnt_next;
  logic [14:0] per_ticks;
  logic [14:0] on_ticks;
  logic wrap;

  assign per_ticks = cswt_per_ticks(t.period_code);
  assign on_ticks = cswt_on_ticks(t.ontime_code);
  assign t.running = cswt_on_valid(t.ontime_code);
  // Compare with >= so a shorter period written mid-count still wraps
  assign wrap = t.running && t.tick && (cnt_reg >= per_ticks - 15'h1);
  assign cnt_next = (!t.running || wrap) ? 15'h0 :
                    t.tick ? cnt_reg + 15'h1 : cnt_reg;
  assign t.on_phase = t.running && (cnt_reg < on_ticks);
  // Activation starts at zero without a wrap, so no first pulse
  assign t.cycle_start = wrap;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 15'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// File: core/cswt_top.sv
// Overview of operation
// - Timer or sync input switches a mapped high-side output on periodically.
// - A level change seen during the on-time makes a wake event.
// - Wake event pulls interrupt low in Normal/Stop, wakes regulator in Sleep.
// - Off-low or off-high code sets high-side level before the timer starts.
// - A non-off on-time starts the timer at once, configured or not.
// - On-time longer than period sets the command fault flag.
// - Sleep request with no valid wake source goes straight to restart.
// - Wake input is sampled once, at the end of each on-phase.
// - A cyclic sense wake also sets that input's wake event flag.
// - In cyclic sense, level status shows only sampled levels.
// - Wake event fires even if the input's flag is already set.
// - Fail-safe turns high-sides off and wake inputs to static sensing.
// - Overcurrent, overtemperature or supply fault in Normal/Stop/Sleep disables that output.
// - Timer wake restarts from Sleep and interrupts in Stop.
// - Sleep request with uncleared flags restarts with reset asserted.
// - Cyclic wake timer interrupts in Normal/Stop, wakes from Sleep.
// - Cyclic wake is enabled by any on-time code but 000, 110, 111.
// - Cyclic wake interrupts each period start except the first.
// - Two timers, each usable for cyclic wake or mapped cyclic sense.
//
// The implementer's own choices: the address map and strobed register access.
module cswt_top
  import cswt_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire cswt_mode_t mode_i,
  input wire logic sleep_req_i,
  input wire logic other_wake_src_i,
  input wire logic [2:0] wake_input_i,
  input wire logic external_sync_input_i,
  input wire logic [2:0] hs_fault_i,
  output logic [2:0] high_side_output_o,
  output logic interrupt_out_n_o,
  output logic reset_out_n_o,
  output logic main_regulator_en_o,
  output logic restart_req_o
);

  logic [7:0] tmr_ctrl_reg [2];
  logic [7:0] hs_cfg_reg;
  logic [7:0] wk_cfg_reg;
  logic [2:0] wk_flag_reg;
  logic [1:0] cw_flag_reg;
  logic cmd_flt_reg;
  logic [2:0] hs_dis_reg;
  logic [2:0] lvl_reg;
  logic [2:0] ref_reg;
  logic [2:0] wake_d_reg;
  logic [2:0] src_on_d_reg;
  logic [2:0] hs_reg;
  logic [11:0] tick_cnt_reg;
  logic [11:0] int_cnt_reg;
  logic int_n_reg;
  logic rst_hold_reg;
  logic rst_n_reg;
  logic reg_en_reg;
  logic restart_reg;
  logic prev_sleep_reg;
  logic [7:0] rdata_reg;

  logic [2:0] wk_flag_next;
  logic [1:0] cw_flag_next;
  logic cmd_flt_next;
  logic [2:0] hs_dis_next;
  logic [2:0] lvl_next;
  logic [2:0] ref_next;
  logic [2:0] hs_next;
  logic [11:0] tick_cnt_next;
  logic [11:0] int_cnt_next;
  logic rst_hold_next;
  logic reg_en_next;
  logic restart_next;
  logic [7:0] rdata_next;

  logic tick;
  logic failsafe;
  logic nor_stop;
  logic in_sleep;
  logic [1:0] trun;
  logic [1:0] ton;
  logic [1:0] tcs;
  logic [1:0] tbad;
  logic [1:0] cw_evt;
  logic [2:0] src_on;
  logic [2:0] src_run;
  logic [2:0] src_bad;
  logic [2:0] init_hi;
  logic [2:0] cs_mode;
  logic [2:0] sample;
  logic [2:0] cs_evt;
  logic [2:0] st_evt;
  logic [2:0] wk_evt;
  logic [2:0] cs_ok;
  logic [2:0] static_en;
  logic evt_any;
  logic int_fire;
  logic wake_fire;
  logic valid_src;
  logic sleep_bad;
  logic wr_hs;
  logic wr_stat;
  logic wr_flt;
  logic [7:0] stat_rd;
  logic [7:0] flt_rd;

  assign failsafe = (mode_i == MODE_FAILSAFE);
  assign nor_stop = (mode_i == MODE_NORMAL) || (mode_i == MODE_STOP);
  assign in_sleep = (mode_i == MODE_SLEEP);
  assign wr_hs = wr_i && (addr_i == ADDR_HS_CFG);
  assign wr_stat = wr_i && (addr_i == ADDR_WAKE_STATUS_FLAGS);
  assign wr_flt = wr_i && (addr_i == ADDR_FAULT);

  // Base tick of 0.1 ms shared by both timers
  assign tick = (tick_cnt_reg == 12'(TICK_CYC - 1));
  assign tick_cnt_next = tick ? 12'h0 : tick_cnt_reg + 12'h1;

  cswt_tmr_if tif [2] ();

  for (genvar j = 0; j < 2; j++) begin : g_tmr
    assign tif[j].tick = tick;
    assign tif[j].period_code = tmr_ctrl_reg[j][TMR_PER_LSB +: 3];
    assign tif[j].ontime_code = tmr_ctrl_reg[j][TMR_ON_LSB +: 3];
    assign trun[j] = tif[j].running;
    assign ton[j] = tif[j].on_phase;
    assign tcs[j] = tif[j].cycle_start;
    assign tbad[j] = trun[j] && (cswt_on_ticks(tif[j].ontime_code) >
                                 cswt_per_ticks(tif[j].period_code));
    // Any running timer may be a wake source as well as a sense source
    assign cw_evt[j] = wk_cfg_reg[WK_CW_LSB + j] && tcs[j] &&
                       !failsafe;

    cswt_timer u_timer (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .t(tif[j])
    );
  end

  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [1:0] sel;
    assign sel = hs_cfg_reg[HS_SEL_W * i +: HS_SEL_W];
    assign src_on[i] = (sel == HS_T1) ? ton[0] :
                       (sel == HS_T2) ? ton[1] :
                       (sel == HS_SYNC) && external_sync_input_i;
    assign src_run[i] = (sel == HS_T1) ? trun[0] :
                        (sel == HS_T2) ? trun[1] : (sel == HS_SYNC);
    assign src_bad[i] = (sel == HS_T1) ? tbad[0] :
                        (sel == HS_T2) && tbad[1];
    assign init_hi[i] =
      (sel == HS_T1) ? (tmr_ctrl_reg[0][2:0] == ON_OFF_HIGH) :
      (sel == HS_T2) && (tmr_ctrl_reg[1][2:0] == ON_OFF_HIGH);
    assign hs_next[i] = !failsafe && !hs_dis_reg[i] &&
                        (src_run[i] ? src_on[i] : init_hi[i]);

    // Fail-safe drops cyclic sensing; the static switch may wake spuriously
    assign cs_mode[i] = wk_cfg_reg[WK_EN_LSB + i] &&
                        wk_cfg_reg[WK_CS_LSB + i] && !failsafe;
    assign static_en[i] = wk_cfg_reg[WK_EN_LSB + i] && !cs_mode[i];
    // Level captured last cycle is the final one of the on-phase
    assign sample[i] = cs_mode[i] && src_run[i] && !hs_dis_reg[i] &&
                       src_on_d_reg[i] && !src_on[i];
    assign cs_evt[i] = sample[i] &&
                       (wake_d_reg[i] != ref_reg[i]);
    assign st_evt[i] = static_en[i] && (wake_input_i[i] != wake_d_reg[i]);
    assign wk_evt[i] = cs_evt[i] || st_evt[i];
    assign cs_ok[i] = cs_mode[i] && src_run[i] && !hs_dis_reg[i] &&
                      !src_bad[i];
    assign ref_next[i] = !src_run[i] ? init_hi[i] :
                         sample[i] ? wake_d_reg[i] : ref_reg[i];
    assign lvl_next[i] = cs_mode[i] ?
                         (sample[i] ? wake_d_reg[i] : lvl_reg[i]) :
                         wake_input_i[i];
    assign hs_dis_next[i] = (hs_fault_i[i] && (nor_stop || in_sleep)) ||
                            (hs_dis_reg[i] && !wr_hs);
  end

  // Set wins over a clear written in the same cycle
  assign wk_flag_next = wk_flag_reg &
                        ~(wr_stat ? wdata_i[STAT_WK_LSB +: 3] : 3'h0) |
                        wk_evt;
  assign cw_flag_next = cw_flag_reg &
                        ~(wr_stat ? wdata_i[STAT_CW_LSB +: 2] : 2'h0) |
                        cw_evt;
  assign cmd_flt_next = (cmd_flt_reg && !(wr_flt && wdata_i[FLT_CMD_BIT])) ||
                        (|tbad);

  assign evt_any = (|wk_evt) || (|cw_evt);
  assign int_fire = evt_any && nor_stop;
  assign wake_fire = evt_any && in_sleep;

  assign valid_src = other_wake_src_i || (|(wk_cfg_reg[WK_CW_LSB +: 2] & trun))
                     || (|static_en) || (|cs_ok);
  assign sleep_bad = sleep_req_i && (mode_i == MODE_NORMAL) &&
                     ((|wk_flag_reg) || (|cw_flag_reg) ||
                      !valid_src);
  assign restart_next = wake_fire || sleep_bad;
  assign rst_hold_next = restart_next ||
                         (rst_hold_reg && (mode_i != MODE_RESTART));
  assign reg_en_next = !in_sleep || wake_fire ||
                       (prev_sleep_reg && reg_en_reg);

  assign int_cnt_next = int_fire ? 12'(INT_LOW_CYC) :
                        (int_cnt_reg != 12'h0) ? int_cnt_reg - 12'h1 : 12'h0;

  assign stat_rd = {2'h0, cw_flag_reg, 1'h0, wk_flag_reg};
  assign flt_rd = {4'h0, hs_dis_reg, cmd_flt_reg};
  assign rdata_next = !rd_i ? 8'h00 :
                      (addr_i == ADDR_TMR1) ? tmr_ctrl_reg[0] :
                      (addr_i == ADDR_TMR2) ? tmr_ctrl_reg[1] :
                      (addr_i == ADDR_HS_CFG) ? hs_cfg_reg :
                      (addr_i == ADDR_WK_CFG) ? wk_cfg_reg :
                      (addr_i == ADDR_WAKE_STATUS_FLAGS) ? stat_rd :
                      (addr_i == ADDR_WK_LVL) ? {5'h0, lvl_reg} :
                      (addr_i == ADDR_FAULT) ? flt_rd : 8'h00;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tmr_ctrl_reg[0] <= TMR_RST;
      tmr_ctrl_reg[1] <= TMR_RST;
      hs_cfg_reg <= HS_CFG_RST;
      wk_cfg_reg <= WK_CFG_RST;
    end else if (wr_i) begin
      if (addr_i == ADDR_TMR1) tmr_ctrl_reg[0] <= wdata_i;
      if (addr_i == ADDR_TMR2) tmr_ctrl_reg[1] <= wdata_i;
      if (addr_i == ADDR_HS_CFG) hs_cfg_reg <= wdata_i;
      if (addr_i == ADDR_WK_CFG) wk_cfg_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wk_flag_reg <= 3'h0;
      cw_flag_reg <= 2'h0;
      cmd_flt_reg <= 1'b0;
      hs_dis_reg <= 3'h0;
      lvl_reg <= 3'h0;
      ref_reg <= 3'h0;
      wake_d_reg <= 3'h0;
      src_on_d_reg <= 3'h0;
      hs_reg <= 3'h0;
    end else begin
      wk_flag_reg <= wk_flag_next;
      cw_flag_reg <= cw_flag_next;
      cmd_flt_reg <= cmd_flt_next;
      hs_dis_reg <= hs_dis_next;
      lvl_reg <= lvl_next;
      ref_reg <= ref_next;
      wake_d_reg <= wake_input_i;
      src_on_d_reg <= src_on;
      hs_reg <= hs_next;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg <= 12'h0;
      int_cnt_reg <= 12'h0;
      int_n_reg <= 1'b1;
      rst_hold_reg <= 1'b0;
      rst_n_reg <= 1'b1;
      reg_en_reg <= 1'b1;
      restart_reg <= 1'b0;
      prev_sleep_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      int_cnt_reg <= int_cnt_next;
      int_n_reg <= (int_cnt_next == 12'h0);
      rst_hold_reg <= rst_hold_next;
      rst_n_reg <= !(rst_hold_next || (mode_i == MODE_RESTART));
      reg_en_reg <= reg_en_next;
      restart_reg <= restart_next;
      prev_sleep_reg <= in_sleep;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign high_side_output_o = hs_reg;
  assign interrupt_out_n_o = int_n_reg;
  assign reset_out_n_o = rst_n_reg;
  assign main_regulator_en_o = reg_en_reg;
  assign restart_req_o = restart_reg;

  sequence s_int_low;
    !interrupt_out_n_o [*8];
  endsequence

  sequence s_hs0_killed;
    hs_dis_reg[0] ##1 !high_side_output_o[0];
  endsequence

  property p_hs_follow;
    @(posedge clk_i) disable iff (!reset_n_i)
    (hs_cfg_reg[1:0] == HS_T1) && trun[0] && !failsafe && !hs_dis_reg[0]
    |=> high_side_output_o[0] == $past(ton[0]);
  endproperty
  a_hs_follow: assert property (p_hs_follow)
    else $error("high-side 0 does not follow timer on-phase");

  property p_cs_int;
    @(posedge clk_i) disable iff (!reset_n_i)
    cs_evt[0] && nor_stop |=> s_int_low;
  endproperty
  a_cs_int: assert property (p_cs_int)
    else $error("cyclic sense event did not pull interrupt low");

  property p_init_lvl;
    @(posedge clk_i) disable iff (!reset_n_i)
    (hs_cfg_reg[1:0] == HS_T1) && (tmr_ctrl_reg[0][2:0] == ON_OFF_HIGH) &&
    !failsafe && !hs_dis_reg[0] |=> high_side_output_o[0];
  endproperty
  a_init_lvl: assert property (p_init_lvl)
    else $error("initial high level not driven");

  property p_cmd_fault;
    @(posedge clk_i) disable iff (!reset_n_i)
    tbad[0] |=> cmd_flt_reg;
  endproperty
  a_cmd_fault: assert property (p_cmd_fault)
    else $error("on-time above period did not set command fault");

  property p_sleep_bad;
    @(posedge clk_i) disable iff (!reset_n_i)
    sleep_req_i && (mode_i == MODE_NORMAL) && (|wk_flag_reg)
    |=> restart_req_o && !reset_out_n_o;
  endproperty
  a_sleep_bad: assert property (p_sleep_bad)
    else $error("sleep with open flags did not restart");

  property p_sample_end;
    @(posedge clk_i) disable iff (!reset_n_i)
    sample[0] |-> $past(ton[0]) || $past(ton[1]) ||
                  $past(external_sync_input_i);
  endproperty
  a_sample_end: assert property (p_sample_end)
    else $error("wake sample taken outside on-phase end");

  property p_flag_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    (cs_evt != 3'h0) |=> ((wk_flag_reg & $past(cs_evt)) == $past(cs_evt));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("wake event flag not set");

  property p_failsafe;
    @(posedge clk_i) disable iff (!reset_n_i)
    failsafe |=> high_side_output_o == 3'h0;
  endproperty
  a_failsafe: assert property (p_failsafe)
    else $error("high-side output on in fail-safe");

  property p_hs_fault;
    @(posedge clk_i) disable iff (!reset_n_i)
    hs_fault_i[0] && nor_stop && !wr_hs |=> s_hs0_killed;
  endproperty
  a_hs_fault: assert property (p_hs_fault)
    else $error("faulted high-side not disabled");

  property p_cw_sleep;
    @(posedge clk_i) disable iff (!reset_n_i)
    cw_evt[0] && in_sleep |=> main_regulator_en_o && restart_req_o;
  endproperty
  a_cw_sleep: assert property (p_cw_sleep)
    else $error("timer wake in sleep did not restart");

  property p_no_first;
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(trun[0]) |-> !tcs[0] ##1 !tcs[0];
  endproperty
  a_no_first: assert property (p_no_first)
    else $error("cyclic wake fired at timer start");

endmodule

// File: dv/cswt_switch_model.sv
// Switch network between a high-side output and its wake input.
// Each wake line has a pull-down, so an open switch or an unpowered
// high-side reads low, never a held value.
module cswt_switch_model (
  input wire logic [2:0] high_side_i,
  input wire logic [2:0] closed_i,
  output logic [2:0] wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign wake_o = high_side_i & closed_i;
endmodule

// File: dv/cyclic_sense_wake_timers_bench.sv
module cyclic_sense_wake_timers_bench
  import cswt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } cswt_row_t;

  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  cswt_mode_t mode_i = MODE_NORMAL;
  logic sleep_req_i = 1'b0;
  logic other_wake_src_i = 1'b0;
  logic [2:0] wake_input_i;
  logic external_sync_input_i = 1'b0;
  logic [2:0] hs_fault_i = 3'h0;
  logic [2:0] sw_closed = 3'h0;
  logic [2:0] high_side_output_o;
  logic interrupt_out_n_o;
  logic reset_out_n_o;
  logic main_regulator_en_o;
  logic restart_req_o;
  logic saw_rst;
  logic saw_int;
  int bad_count = 0;
  int n_checks = 0;

  // Read-back expectations; all these registers reset to zero
  cswt_row_t rows [9] = '{
    '{ADDR_TMR1, 8'h70, 8'h70},
    '{ADDR_TMR2, 8'h50, 8'h50},
    '{ADDR_HS_CFG, 8'h3f, 8'h3f},
    '{ADDR_WK_CFG, 8'hc0, 8'hc0},
    '{ADDR_WAKE_STATUS_FLAGS, 8'hff, 8'h00},
    '{ADDR_WK_LVL, 8'hff, 8'h00},
    '{ADDR_FAULT, 8'hff, 8'h00},
    '{8'h07, 8'h5a, 8'h00},
    '{8'hff, 8'h01, 8'h00}
  };

  always #20 clk_i = ~clk_i;

  cswt_top dut_u (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .mode_i(mode_i),
    .sleep_req_i(sleep_req_i),
    .other_wake_src_i(other_wake_src_i),
    .wake_input_i(wake_input_i),
    .external_sync_input_i(external_sync_input_i),
    .hs_fault_i(hs_fault_i),
    .high_side_output_o(high_side_output_o),
    .interrupt_out_n_o(interrupt_out_n_o),
    .reset_out_n_o(reset_out_n_o),
    .main_regulator_en_o(main_regulator_en_o),
    .restart_req_o(restart_req_o)
  );

  cswt_switch_model sw_u (
    .high_side_i(high_side_output_o),
    .closed_i(sw_closed),
    .wake_o(wake_input_i)
  );

  task final_report;
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Records any restart pulse or low interrupt over n cycles
  task watch(input int n);
    saw_rst = 1'b0;
    saw_int = 1'b0;
    repeat (n) begin
      #1;
      if (restart_req_o === 1'b1) saw_rst = 1'b1;
      if (interrupt_out_n_o === 1'b0) saw_int = 1'b1;
      @(posedge clk_i);
    end
    #1;
  endtask

  task wait_hs_low(input int lim);
    int i;
    for (i = 0; i < lim && high_side_output_o[0] !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == lim) begin
      bad_count++;
      final_report();
    end
  endtask

  task pulse_sleep;
    @(posedge clk_i);
    sleep_req_i <= 1'b1;
    @(posedge clk_i);
    sleep_req_i <= 1'b0;
  endtask

  task do_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    mode_i <= MODE_NORMAL;
    sw_closed <= 3'h0;
    other_wake_src_i <= 1'b0;
    wait_cyc(20);
    chk({1'b0, high_side_output_o, interrupt_out_n_o, reset_out_n_o,
         main_regulator_en_o, restart_req_o}, 8'h0e);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask

  // Cyclic sense on HS0/wake 0, init level low (off-low code), timer left stopped
  task sense_setup;
    wr(ADDR_HS_CFG, 8'h01);
    wr(ADDR_WK_CFG, 8'h09);
    wr(ADDR_TMR1, 8'h06);
    @(posedge clk_i);
    sw_closed <= 3'h1;
  endtask

  initial begin
    do_reset();
    foreach (rows[k]) begin
      rd(rows[k].a, 8'h00);
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a, rows[k].e);
    end
    do_reset();
    wr(ADDR_HS_CFG, 8'h01);
    wr(ADDR_TMR1, 8'h07);
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b1);
    wr(ADDR_TMR1, 8'h06);
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b0);
    wr(ADDR_TMR1, 8'h02);
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b1);
    wait_cyc(4900);
    chk1(high_side_output_o[0], 1'b1);
    wait_hs_low(2700);
    chk1(high_side_output_o[0], 1'b0);
    wr(ADDR_HS_CFG, 8'h03);
    external_sync_input_i <= 1'b1;
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b1);
    @(posedge clk_i);
    external_sync_input_i <= 1'b0;
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b0);
    wr(ADDR_TMR2, 8'h05);
    rd(ADDR_FAULT, 8'h01);
    wr(ADDR_TMR2, 8'h15);
    wr(ADDR_FAULT, 8'h01);
    rd(ADDR_FAULT, 8'h00);
    wr(ADDR_HS_CFG, 8'h01);
    // Init-high level keeps HS0 on, so the fault has something to cut
    wr(ADDR_TMR1, 8'h07);
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b1);
    @(posedge clk_i);
    hs_fault_i <= 3'h1;
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b0);
    rd(ADDR_FAULT, 8'h02);
    @(posedge clk_i);
    hs_fault_i <= 3'h0;
    wr(ADDR_HS_CFG, 8'h01);
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b1);
    @(posedge clk_i);
    mode_i <= MODE_FAILSAFE;
    wait_cyc(3);
    chk1(high_side_output_o[0], 1'b0);
    do_reset();
    sense_setup();
    wr(ADDR_TMR1, 8'h02);
    rd(ADDR_WK_LVL, 8'h00);
    watch(4800);
    chk1(saw_int, 1'b0);
    wait_hs_low(2800);
    watch(3);
    chk1(saw_int, 1'b1);
    rd(ADDR_WAKE_STATUS_FLAGS, 8'h01);
    rd(ADDR_WK_LVL, 8'h01);
    @(posedge clk_i);
    other_wake_src_i <= 1'b1;
    pulse_sleep();
    watch(4);
    chk1(saw_rst, 1'b1);
    chk1(reset_out_n_o, 1'b0);
    @(posedge clk_i);
    mode_i <= MODE_RESTART;
    wait_cyc(2);
    @(posedge clk_i);
    mode_i <= MODE_NORMAL;
    wait_cyc(3);
    chk1(reset_out_n_o, 1'b1);
    wr(ADDR_WAKE_STATUS_FLAGS, 8'h01);
    pulse_sleep();
    watch(4);
    chk1(saw_rst, 1'b0);
    do_reset();
    sense_setup();
    mode_i <= MODE_SLEEP;
    wr(ADDR_TMR1, 8'h02);
    wait_cyc(3);
    wait_hs_low(7600);
    watch(3);
    chk1(saw_rst, 1'b1);
    chk1(saw_int, 1'b0);
    chk1(main_regulator_en_o, 1'b1);
    do_reset();
    wr(ADDR_WK_CFG, 8'h40);
    wr(ADDR_TMR1, 8'h71);
    watch(3000);
    chk1(saw_int, 1'b0);
    // Long period keeps the timer from wrapping during the sweep
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_TMR1, {5'h0e, 3'(c)});
      pulse_sleep();
      watch(4);
      chk1(saw_rst, (c == 0 || c == 6 || c == 7));
      @(posedge clk_i);
      mode_i <= MODE_RESTART;
      @(posedge clk_i);
      mode_i <= MODE_NORMAL;
    end
    final_report();
  end
endmodule
